// ### common/cme_pkg.sv
package cme_pkg;
  // Word, field and stack geometry
  localparam int INSTR_W = 10;
  localparam int PC_W = 14;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int NIB_W = 4;
  localparam int X_W = 4;
  localparam int Y_W = 4;
  localparam int Z_W = 2;
  localparam int DP_W = Z_W + X_W + Y_W;
  localparam int TMR_W = 8;
  localparam int BIT_J_W = 2;
  // Opcodes
  localparam logic [9:0] CLEAR_CARRY_OP = 10'h006;
  localparam logic [9:0] SUBROUTINE_RETURN_OP = 10'h044;
  localparam logic [9:0] SET_MEMORY_BIT_OP = 10'h05C;
  localparam logic [9:0] SET_MEMORY_BIT_MASK = 10'h3FC;
  localparam logic [9:0] SKIP_IF_ACC_MATCHES_MEM_OP = 10'h026;
  localparam logic [9:0] LOAD_TIMER_TWO_OP = 10'h231;
  localparam logic [9:0] LOAD_TIMER_THREE_OP = 10'h232;
  localparam logic [9:0] LOAD_TIMER_FOUR_HIGH_RELOAD_OP = 10'h237;
  // Reset values and step sizes
  localparam logic [13:0] PC_RST = 14'h0000;
  localparam logic [2:0] SP_RST = 3'h7;
  localparam logic [7:0] TMR_RST = 8'h00;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [13:0] PC_STEP = 14'h0001;
  localparam logic [2:0] SP_STEP = 3'h1;
endpackage

// ### rtl/cme_mem_bit_set.sv
`timescale 1ns/1ns
// Sets one bit of a nibble, chosen by a two bit index
module cme_mem_bit_set #(
  parameter int WIDTH = 4
) (
  // Data in and out
  input wire logic [WIDTH-1:0] nib_in,
  input wire logic [$clog2(WIDTH)-1:0] bit_sel,
  output logic [WIDTH-1:0] nib_out
);
  // Refuse widths that the bit index cannot cover exactly
  if (WIDTH < 2 || (WIDTH & (WIDTH - 1)) != 0)
  begin
    $error("cme_mem_bit_set: WIDTH must be a power of two, at least 2");
  end

  // Or in the selected bit
  always_comb
  begin
    nib_out = nib_in;
    nib_out[bit_sel] = 1'b1;
  end
endmodule

// ### rtl/cme_misc_exec.sv
`timescale 1ns/1ns
// What this block does
// - Clear carry op forces carry flag to zero unless carry set comes in the same cycle, which wins; others unchanged.
// - Return loads program counter from stack entry at index, then index decrements.
// - Set bit op writes one into bit j of addressed memory nibble.
// - Compare op skips next instruction when accumulator equals addressed nibble.
// - Timer two load puts B high, A low into counter and reload.
// - Timer three load puts B high, A low into counter and reload.
// - Timer four high load puts B high, A low into counter and high reload.
// - Skip nullifies the next instruction; program counter still steps by one.
// - Data pointer is ten bits, made of two, four and four bit indexes.
// - Return stack is eight entries of fourteen bits, indexed by three bits.
module cme_misc_exec
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Fetched instruction
  input wire logic instr_valid,
  input wire logic [cme_pkg::INSTR_W-1:0] instr_word,
  // Working registers from the core
  input wire logic [cme_pkg::NIB_W-1:0] acc_in,
  input wire logic [cme_pkg::NIB_W-1:0] reg_b_in,
  input wire logic [cme_pkg::X_W-1:0] dp_x_in,
  input wire logic [cme_pkg::Y_W-1:0] dp_y_in,
  input wire logic [cme_pkg::Z_W-1:0] dp_z_in,
  // Data memory read port, same clock
  input wire logic [cme_pkg::NIB_W-1:0] mem_rdata,
  // Return stack push from the call logic
  input wire logic push_valid,
  input wire logic [cme_pkg::PC_W-1:0] push_addr,
  // Carry set from the core's arithmetic, same clock
  input wire logic carry_set,
  // Data memory address and write
  output logic [cme_pkg::DP_W-1:0] data_pointer,
  output logic mem_we,
  output logic [cme_pkg::NIB_W-1:0] mem_wdata,
  // Core state
  output logic carry_flag,
  output logic [cme_pkg::PC_W-1:0] program_counter,
  output logic [cme_pkg::SP_W-1:0] return_stack_index,
  output logic skip_pending,
  // Timers
  output logic [cme_pkg::TMR_W-1:0] timer_two_count,
  output logic [cme_pkg::TMR_W-1:0] timer_two_reload,
  output logic [cme_pkg::TMR_W-1:0] timer_three_count,
  output logic [cme_pkg::TMR_W-1:0] timer_three_reload,
  output logic [cme_pkg::TMR_W-1:0] timer_four_count,
  output logic [cme_pkg::TMR_W-1:0] timer_four_high_reload
);
  import cme_pkg::*;

  logic [PC_W-1:0] return_stack [STACK_DEPTH];
  logic [SP_W-1:0] push_slot;
  logic [DP_W-1:0] dp_now;
  logic [NIB_W-1:0] set_nib;
  logic [TMR_W-1:0] ab_word;
  logic exec;
  logic is_clear_carry;
  logic is_return;
  logic is_set_bit;
  logic is_compare;
  logic is_tmr2;
  logic is_tmr3;
  logic is_tmr4h;

  // Pointer formed combinationally, then registered with the write, so data_pointer lags one cycle
  assign dp_now = {dp_z_in, dp_x_in, dp_y_in};
  assign ab_word = {reg_b_in, acc_in};

  // Index wraps modulo the depth; a ninth push overwrites the oldest entry
  assign push_slot = return_stack_index + SP_STEP;

  // A nullified word still takes its cycle and steps the program counter, but executes nothing
  assign exec = instr_valid && !skip_pending;
  assign is_clear_carry = exec && (instr_word == CLEAR_CARRY_OP);
  assign is_return = exec && (instr_word == SUBROUTINE_RETURN_OP);
  assign is_set_bit = exec && ((instr_word & SET_MEMORY_BIT_MASK) == SET_MEMORY_BIT_OP);
  assign is_compare = exec && (instr_word == SKIP_IF_ACC_MATCHES_MEM_OP);
  assign is_tmr2 = exec && (instr_word == LOAD_TIMER_TWO_OP);
  assign is_tmr3 = exec && (instr_word == LOAD_TIMER_THREE_OP);
  assign is_tmr4h = exec && (instr_word == LOAD_TIMER_FOUR_HIGH_RELOAD_OP);

  // Geometry the logic leans on; anything else would wrap or truncate silently
  if (STACK_DEPTH != 2 ** SP_W)
  begin
    $error("cme_misc_exec: stack depth must match the index width");
  end
  if (TMR_W != 2 * NIB_W)
  begin
    $error("cme_misc_exec: timer byte must be two nibbles");
  end
  if (NIB_W != 2 ** BIT_J_W)
  begin
    $error("cme_misc_exec: bit field must cover one nibble");
  end
  if (INSTR_W != $bits(CLEAR_CARRY_OP))
  begin
    $error("cme_misc_exec: opcode width must match the instruction word");
  end

  cme_mem_bit_set #(
    .WIDTH(NIB_W)
  ) u_bit_set (
    .nib_in(mem_rdata),
    .bit_sel(instr_word[BIT_J_W-1:0]),
    .nib_out(set_nib)
  );

  // Carry flag; the core never sets carry in the cycle that executes the clear,
  // so the set branch only wins when the core itself misbehaves
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      carry_flag <= 1'b0;
    else if (carry_set)
      carry_flag <= 1'b1;
    else if (is_clear_carry)
      carry_flag <= 1'b0;
  end

  // Program counter: one word per instruction, return reloads it
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      program_counter <= PC_RST;
    else if (is_return)
      program_counter <= return_stack[return_stack_index];
    else if (instr_valid)
      program_counter <= program_counter + PC_STEP;
  end

  // Stack index; a push and a return can both arrive in one cycle
  // The return wins, so a stray push cannot corrupt the entry being popped
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      return_stack_index <= SP_RST;
    else if (is_return)
      return_stack_index <= return_stack_index - SP_STEP;
    else if (push_valid)
      return_stack_index <= push_slot;
  end

  // Stack storage, no reset needed on data words
  always_ff @(posedge sys_clk)
  begin
    if (push_valid && !is_return)
      return_stack[push_slot] <= push_addr;
  end

  // Skip decision applies to the very next fetched word
  // A nullified compare clears the flag, so skips never chain
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      skip_pending <= 1'b0;
    else if (instr_valid)
      skip_pending <= is_compare && (acc_in == mem_rdata);
  end

  // Memory write, registered so outputs come from flops
  // Address and data move together, so the write lands where the read was
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      mem_we <= 1'b0;
      mem_wdata <= NIB_RST;
      data_pointer <= '0;
    end
    else
    begin
      mem_we <= is_set_bit;
      mem_wdata <= set_nib;
      data_pointer <= dp_now;
    end
  end

  // Timer two
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      timer_two_count <= TMR_RST;
      timer_two_reload <= TMR_RST;
    end
    else if (is_tmr2)
    begin
      timer_two_count <= ab_word;
      timer_two_reload <= ab_word;
    end
  end

  // Timer three
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      timer_three_count <= TMR_RST;
      timer_three_reload <= TMR_RST;
    end
    else if (is_tmr3)
    begin
      timer_three_count <= ab_word;
      timer_three_reload <= ab_word;
    end
  end

  // Timer four, high reload path only
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      timer_four_count <= TMR_RST;
      timer_four_high_reload <= TMR_RST;
    end
    else if (is_tmr4h)
    begin
      timer_four_count <= ab_word;
      timer_four_high_reload <= ab_word;
    end
  end
endmodule

// ### tb/cme_pmem.sv
`timescale 1ns/1ns
// Program memory stand-in; a released bus shows the inverted word, not the last one
module cme_pmem (
  // From bench
  input wire logic fetch_en,
  input wire logic [9:0] fetch_word,
  // To core
  output logic instr_valid,
  output logic [9:0] instr_word
);
  assign instr_valid = fetch_en;
  assign instr_word = fetch_en ? fetch_word : ~fetch_word;
endmodule

// ### tb/cme_misc_chk.sv
`timescale 1ns/1ns
module cme_misc_chk
  import cme_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  // Core inputs
  input wire logic [3:0] acc_in,
  input wire logic [3:0] reg_b_in,
  input wire logic [3:0] mem_rdata,
  input wire logic [3:0] dp_x_in,
  input wire logic [3:0] dp_y_in,
  input wire logic [1:0] dp_z_in,
  input wire logic carry_set,
  // Observed state
  input wire logic skip_pending,
  input wire logic carry_flag,
  input wire logic mem_we,
  input wire logic [3:0] mem_wdata,
  input wire logic [9:0] data_pointer,
  input wire logic [13:0] program_counter,
  input wire logic [2:0] return_stack_index,
  input wire logic [7:0] timer_two_count,
  input wire logic [7:0] timer_two_reload,
  input wire logic [7:0] timer_three_count,
  input wire logic [7:0] timer_three_reload,
  input wire logic [7:0] timer_four_count,
  input wire logic [7:0] timer_four_high_reload
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // An executed word, not one nullified by a skip
  sequence go(op);
    instr_valid && !skip_pending && instr_word == op;
  endsequence
  carry_clr_a: assert property (!carry_set ##0 go(CLEAR_CARRY_OP) |=> !carry_flag)
    else $error("carry not cleared");
  ret_pop_a: assert property (go(SUBROUTINE_RETURN_OP) |=>
    return_stack_index == $past(return_stack_index) - 3'h1) else $error("index not popped");
  set_bit_a: assert property (go({SET_MEMORY_BIT_OP[9:2], instr_word[1:0]}) |=>
    mem_we && mem_wdata == ($past(mem_rdata) | (4'h1 << $past(instr_word[1:0]))))
    else $error("bit set wrong");
  skip_a: assert property (go(SKIP_IF_ACC_MATCHES_MEM_OP) |=>
    skip_pending == ($past(acc_in) == $past(mem_rdata))) else $error("skip decision wrong");
  null_a: assert property (instr_valid && skip_pending |=>
    !skip_pending && $stable(timer_two_count)) else $error("skipped word acted");
  pc_a: assert property (instr_valid && (skip_pending || instr_word != SUBROUTINE_RETURN_OP)
    |=> program_counter == $past(program_counter) + 14'h0001) else $error("pc step wrong");
  t2_a: assert property (go(LOAD_TIMER_TWO_OP) |=> timer_two_reload == timer_two_count &&
    timer_two_count == {$past(reg_b_in), $past(acc_in)}) else $error("timer two load wrong");
  t3_a: assert property (go(LOAD_TIMER_THREE_OP) |=>
    timer_three_count == {$past(reg_b_in), $past(acc_in)} && timer_three_reload ==
    timer_three_count) else $error("timer three load wrong");
  t4_a: assert property (go(LOAD_TIMER_FOUR_HIGH_RELOAD_OP) |=>
    timer_four_count == {$past(reg_b_in), $past(acc_in)} && timer_four_high_reload ==
    timer_four_count) else $error("timer four load wrong");
  dp_a: assert property ($past(nrst) |->
    data_pointer == $past({dp_z_in, dp_x_in, dp_y_in})) else $error("pointer wrong");
endmodule
bind cme_misc_exec cme_misc_chk u_chk (.*);

// ### tb/cme_misc_exec_tb.sv
`timescale 1ns/1ns
module cme_misc_exec_tb;
  import cme_pkg::*;
  logic sys_clk = 0, nrst = 0, fen = 0, pv = 0, cs = 0, we, cy, sk, iv;
  logic [9:0] fw = 0, iw, dp;
  logic [3:0] a = 0, b = 0, x = 0, y = 0, m = 0, wd;
  logic [1:0] z = 0;
  logic [13:0] pa = 0, pc;
  logic [2:0] si;
  logic [7:0] t2, r2, t3, r3, t4, r4;
  int bad_count = 0, n_tests = 0;
  cme_pmem pm (.fetch_en(fen), .fetch_word(fw), .instr_valid(iv), .instr_word(iw));
  cme_misc_exec dut (.sys_clk(sys_clk), .nrst(nrst), .instr_valid(iv), .instr_word(iw),
    .acc_in(a), .reg_b_in(b), .dp_x_in(x), .dp_y_in(y), .dp_z_in(z), .mem_rdata(m),
    .push_valid(pv), .push_addr(pa), .carry_set(cs), .data_pointer(dp), .mem_we(we),
    .mem_wdata(wd),
    .carry_flag(cy), .program_counter(pc), .return_stack_index(si), .skip_pending(sk),
    .timer_two_count(t2), .timer_two_reload(r2), .timer_three_count(t3),
    .timer_three_reload(r3), .timer_four_count(t4), .timer_four_high_reload(r4));
  initial forever #25 sys_clk = ~sys_clk;
  // Expected timer byte, B high and A low
  function automatic logic [7:0] tb_byte(input logic [3:0] hi, lo);
    return {hi, lo};
  endfunction
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One word per cycle; inputs move 5 ns after the edge
  task automatic ex(input logic [9:0] w);
    fw = w;
    fen = 1;
    @(posedge sys_clk);
    #5;
  endtask
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #1000000;
    bad_count++;
    end_sim;
  end
  initial
  begin
    logic [13:0] sa [3];
    logic [7:0] e [3];
    logic [9:0] ops [3];
    logic [13:0] p0;
    ops = '{LOAD_TIMER_TWO_OP, LOAD_TIMER_THREE_OP, LOAD_TIMER_FOUR_HIGH_RELOAD_OP};
    void'($urandom(32'h7a2c_0bf9));
    repeat (2) @(posedge sys_clk);
    #5;
    nrst = 1;
    chk({pc, si, sk, cy}, {14'h0000, 3'h7, 2'b00});
    // Three pushes, then two returns back to back
    for (int i = 0; i < 3; i++)
    begin
      pa = 14'($urandom);
      sa[i] = pa;
      pv = 1;
      @(posedge sys_clk);
      #5;
    end
    pv = 0;
    ex(SUBROUTINE_RETURN_OP);
    chk({pc, si}, {sa[2], 3'h1});
    ex(SUBROUTINE_RETURN_OP);
    chk({pc, si}, {sa[1], 3'h0});
    $display("return test done");
    for (int i = 0; i < 3; i++)
    begin
      a = 4'($urandom);
      b = 4'($urandom);
      e[i] = tb_byte(b, a);
      ex(ops[i]);
    end
    chk({t2, r2, t3, r3}, {e[0], e[0], e[1], e[1]});
    chk({t4, r4}, {e[2], e[2]});
    $display("timer test done");
    for (int j = 0; j < 4; j++)
    begin
      m = 4'($urandom);
      {z, x, y} = 10'($urandom);
      ex(SET_MEMORY_BIT_OP | 10'(j));
      chk({we, wd}, {1'b1, m | (4'h1 << j)});
      chk(dp, {z, x, y});
    end
    $display("set bit test done");
    p0 = pc;
    m = a;
    ex(SKIP_IF_ACC_MATCHES_MEM_OP);
    chk(sk, 1'b1);
    b = ~b;
    ex(LOAD_TIMER_TWO_OP);
    chk({sk, t2}, {1'b0, e[0]});
    m = ~a;
    ex(SKIP_IF_ACC_MATCHES_MEM_OP);
    chk(sk, 1'b0);
    ex(LOAD_TIMER_TWO_OP);
    chk({t2, pc}, {tb_byte(b, a), p0 + 14'h0004});
    cs = 1;
    @(posedge sys_clk);
    #5;
    cs = 0;
    chk(cy, 1'b1);
    ex(CLEAR_CARRY_OP);
    chk({cy, t2, pc}, {1'b0, tb_byte(b, a), p0 + 14'h0006});
    fen = 0;
    $display("skip and carry test done");
    end_sim;
  end
endmodule
